// ==== virtual_io_signal_matrix.sv ====
// virtual inputs/outputs, output matrix, blocking matrix, ahb-lite registers
//
// What this block does
// RULE1 - virtual inputs are stored, writable bits
// RULE2 - virtual input writes act within 5 ms
// RULE3 - twenty virtual inputs and twenty virtual outputs
// RULE4 - virtual output writable only while forced
// RULE5 - virtual bits reach logic operators, latched optional
// RULE6 - function keys and mimic also drive inputs
// RULE7 - output matrix routes any source anywhere
// RULE8 - eight lettered indicators, own routing slots
// RULE9 - two function key indicators are routable
// RULE10 - non-latched destination follows its control; forced virtual outputs take bus writes instead
// RULE11 - latched destination holds until latch release
// RULE12 - one release clears all latched destinations; forced virtual outputs keep their value (a latched destination whose control is still on stays set)
// RULE13 - release from input, panel or remote
// RULE14 - blocking matrix inhibits stages by signal
// RULE15 - blocked status only when blocked and picking
// RULE16 - release acts only on active latched outputs
// RULE17 - enabled channel changes raise event records
`timescale 1ns/100ps
`default_nettype none
module virtual_io_signal_matrix
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [7:0]  dig_in,
    input  wire logic        function_key_one,
    input  wire logic        function_key_two,
    input  wire logic        panel_release,
    input  wire logic        remote_release,
    input  wire logic [3:0]  stage_start,
    input  wire logic [3:0]  stage_trip,
    input  wire logic [3:0]  stage_pickup,
    input  wire logic [3:0]  logic_out,
    input  wire logic [1:0]  alarm,
    input  wire logic        mimic_we,
    input  wire logic [4:0]  mimic_index,
    input  wire logic        mimic_value,
    output logic      [19:0] stored_input_bits,
    output logic      [19:0] stored_output_bits,
    output logic      [7:0]  digital_out,
    output logic      [7:0]  indicator,
    output logic      [1:0]  function_key_led,
    output logic             fault_recorder_trigger,
    output logic      [3:0]  stage_block,
    output logic      [3:0]  stage_blocked_status,
    output logic             irq
);

    // ========================================================
    // declarations
    logic [9:0]  route_cfg [vio_pkg::NDEST];
    logic [8:0]  block_cfg [vio_pkg::NSTG];
    logic [11:0] ctrl;
    logic [13:0] fk_cfg;
    logic [19:0] vi_ev_en;
    logic [19:0] vo_ev_en;
    logic [19:0] st_vi;
    logic [19:0] st_vo;
    logic [19:0] mask_vi;
    logic [19:0] mask_vo;
    logic        rel_sw;
    logic [38:20] dest_q;
    logic [7:0]  di_s1;
    logic [7:0]  di_s2;
    logic [1:0]  fk_s1;
    logic [1:0]  fk_s2;
    logic [1:0]  fk_s3;
    logic        pr_s1;
    logic        pr_s2;
    logic        dp_wr;
    logic        dp_rd;
    logic [7:0]  dp_addr;
    logic [31:0] rd_mux;
    logic [19:0] next_vi;
    logic [19:0] next_vo;
    logic [19:0] next_st_vi;
    logic [19:0] next_st_vo;
    logic [3:0]  next_block;

    wire  [63:0] src;
    wire  [38:0] en_v;
    wire  [38:0] lat_v;
    wire  [38:0] ctl;
    wire  [38:0] cur_v;
    wire  [38:0] next_dest;
    wire  [1:0]  fk_rise;
    wire         rel_now;
    wire         ap;
    wire  [19:0] hw_lo;
    wire  [7:0]  r_off;
    wire  [5:0]  r_idx;
    wire         r_hit;
    wire  [7:0]  b_off;
    wire  [1:0]  b_idx;
    wire         b_hit;
    wire         force_on;
    wire  [4:0]  k1_idx;
    wire  [4:0]  k2_idx;
    wire  [2:0]  rdi_idx;

    // ========================================================
    // pin synchronisers
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            di_s1 <= 8'h00;
            di_s2 <= 8'h00;
            fk_s1 <= 2'h0;
            fk_s2 <= 2'h0;
            fk_s3 <= 2'h0;
            pr_s1 <= 1'b0;
            pr_s2 <= 1'b0;
        end
        else
        begin
            di_s1 <= dig_in;
            di_s2 <= di_s1;
            fk_s1 <= {function_key_two, function_key_one};
            fk_s2 <= fk_s1;
            fk_s3 <= fk_s2;
            pr_s1 <= panel_release;
            pr_s2 <= pr_s1;
        end
    end

    assign fk_rise = fk_s2 & ~fk_s3;

    // ========================================================
    // ahb-lite slave decode
    assign ap     = hsel & hready & htrans[1];
    assign hw_lo  = hwdata[19:0];
    assign r_off  = dp_addr - vio_pkg::A_ROUTE;
    assign r_idx  = r_off[7:2];
    assign r_hit  = (dp_addr >= vio_pkg::A_ROUTE) && (dp_addr < vio_pkg::A_REND);
    assign b_off  = dp_addr - vio_pkg::A_BLOCK;
    assign b_idx  = b_off[3:2];
    assign b_hit  = (dp_addr >= vio_pkg::A_BLOCK) && (dp_addr < vio_pkg::A_BEND);

    wire wr_vi   = dp_wr && (dp_addr == vio_pkg::A_VI);
    wire wr_vo   = dp_wr && (dp_addr == vio_pkg::A_VO);
    wire wr_ctrl = dp_wr && (dp_addr == vio_pkg::A_CTRL);
    wire wr_fkey = dp_wr && (dp_addr == vio_pkg::A_FKEY);
    wire wr_viev = dp_wr && (dp_addr == vio_pkg::A_VIEV);
    wire wr_voev = dp_wr && (dp_addr == vio_pkg::A_VOEV);
    wire wr_stvi = dp_wr && (dp_addr == vio_pkg::A_STVI);
    wire wr_stvo = dp_wr && (dp_addr == vio_pkg::A_STVO);
    wire wr_mkvi = dp_wr && (dp_addr == vio_pkg::A_MKVI);
    wire wr_mkvo = dp_wr && (dp_addr == vio_pkg::A_MKVO);
    wire wr_rte  = dp_wr && r_hit;
    wire wr_blk  = dp_wr && b_hit;

    assign force_on = ctrl[vio_pkg::C_FORCE];
    assign k1_idx   = fk_cfg[vio_pkg::K1_MSB:0];
    assign k2_idx   = fk_cfg[vio_pkg::K2_MSB:vio_pkg::K2_LSB];
    assign rdi_idx  = ctrl[vio_pkg::C_RDI_MSB:vio_pkg::C_RDI_LSB];

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dp_wr     <= 1'b0;
            dp_rd     <= 1'b0;
            dp_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end
        else
        begin
            dp_wr     <= ap & hwrite;
            dp_rd     <= ap & ~hwrite;
            hreadyout <= ~(ap & ~hwrite);
            hresp     <= 1'b0;
            if (ap)
                dp_addr <= haddr;
            if (dp_rd)
                hrdata <= rd_mux;
        end
    end

    always_comb
    begin
        rd_mux = 32'h00000000;
        if (r_hit)
            rd_mux[9:0] = route_cfg[r_idx];
        else if (b_hit)
            rd_mux[8:0] = block_cfg[b_idx];
        else
            case (dp_addr)
                vio_pkg::A_VI:   rd_mux[19:0] = stored_input_bits;
                vio_pkg::A_VO:   rd_mux[19:0] = stored_output_bits;
                vio_pkg::A_CTRL: rd_mux[11:0] = ctrl;
                vio_pkg::A_FKEY: rd_mux[13:0] = fk_cfg;
                vio_pkg::A_VIEV: rd_mux[19:0] = vi_ev_en;
                vio_pkg::A_VOEV: rd_mux[19:0] = vo_ev_en;
                vio_pkg::A_STVI: rd_mux[19:0] = st_vi;
                vio_pkg::A_STVO: rd_mux[19:0] = st_vo;
                vio_pkg::A_MKVI: rd_mux[19:0] = mask_vi;
                vio_pkg::A_MKVO: rd_mux[19:0] = mask_vo;
                vio_pkg::A_STAT: rd_mux[22:0] = {fault_recorder_trigger, function_key_led,
                                                 indicator, digital_out, stage_blocked_status};
                default:         rd_mux = 32'h00000000;
            endcase
    end

    // ========================================================
    // configuration registers
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < vio_pkg::NDEST; i++)
                route_cfg[i] <= vio_pkg::R_ROUTE;
            for (int i = 0; i < vio_pkg::NSTG; i++)
                block_cfg[i] <= vio_pkg::R_BLOCK;
            ctrl     <= vio_pkg::R_CTRL;
            fk_cfg   <= vio_pkg::R_FKEY;
            vi_ev_en <= vio_pkg::R_BITS;
            vo_ev_en <= vio_pkg::R_BITS;
            mask_vi  <= vio_pkg::R_BITS;
            mask_vo  <= vio_pkg::R_BITS;
            rel_sw   <= 1'b0;
        end
        else
        begin
            if (wr_rte)
                route_cfg[r_idx] <= {hwdata[9:8], 2'h0, hwdata[5:0]};
            if (wr_blk)
                block_cfg[b_idx] <= {hwdata[8], 2'h0, hwdata[5:0]};
            if (wr_ctrl)
                ctrl <= {hwdata[11:8], 7'h00, hwdata[0]};
            if (wr_fkey)
                fk_cfg <= {hwdata[13:8], 2'h0, hwdata[5:0]};
            if (wr_viev)
                vi_ev_en <= hw_lo;
            if (wr_voev)
                vo_ev_en <= hw_lo;
            if (wr_mkvi)
                mask_vi <= hw_lo;
            if (wr_mkvo)
                mask_vo <= hw_lo;
            rel_sw <= wr_ctrl & hwdata[vio_pkg::C_REL];
        end
    end

    // ========================================================
    // virtual inputs
    always_comb
    begin
        next_vi = stored_input_bits;
        if (fk_rise[0] && fk_cfg[vio_pkg::K1_EN] && (k1_idx < vio_pkg::NVI))
            next_vi[k1_idx] = ~stored_input_bits[k1_idx]; // [RULE6]
        if (fk_rise[1] && fk_cfg[vio_pkg::K2_EN] && (k2_idx < vio_pkg::NVI))
            next_vi[k2_idx] = ~stored_input_bits[k2_idx]; // [RULE6]
        if (mimic_we && (mimic_index < vio_pkg::NVI))
            next_vi[mimic_index] = mimic_value; // [RULE6]
        if (wr_vi)
            next_vi = hw_lo; // [RULE1] [RULE2] [RULE3]
    end

    // ========================================================
    // output matrix
    // source slots: vi, vo, inputs, starts, trips, logic, alarms, keys
    assign src = {fk_s2, alarm, logic_out, stage_trip, stage_start, di_s2,
                  stored_output_bits, stored_input_bits}; // [RULE5] [RULE7]

    assign rel_now = rel_sw | pr_s2 | remote_release
                   | (ctrl[vio_pkg::C_RDI_EN] & di_s2[rdi_idx]); // [RULE13]

    assign cur_v = {dest_q, stored_output_bits};

    genvar d;
    generate
        for (d = 0; d < vio_pkg::NDEST; d++)
        begin : g_dest
            assign en_v[d]  = route_cfg[d][vio_pkg::F_EN];
            assign lat_v[d] = route_cfg[d][vio_pkg::F_LAT];
            assign ctl[d]   = en_v[d] & src[route_cfg[d][vio_pkg::F_IDX_MSB:0]]; // [RULE7]
            // control wins; a latch holds only while active and unreleased
            assign next_dest[d] = ctl[d] | (lat_v[d] & cur_v[d] & ~rel_now); // [RULE10] [RULE11] [RULE12] [RULE16]
        end
    endgenerate

    assign next_vo = force_on ? (wr_vo ? hw_lo : stored_output_bits)
                              : next_dest[19:0]; // [RULE4]

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dest_q             <= 19'h00000;
            stored_input_bits  <= vio_pkg::R_BITS;
            stored_output_bits <= vio_pkg::R_BITS;
        end
        else
        begin
            dest_q             <= next_dest[38:20]; // [RULE8] [RULE9]
            stored_input_bits  <= next_vi;
            stored_output_bits <= next_vo;
        end
    end

    assign digital_out            = dest_q[vio_pkg::D_DO+7:vio_pkg::D_DO];
    assign indicator              = dest_q[vio_pkg::D_LED+7:vio_pkg::D_LED];
    assign function_key_led       = dest_q[vio_pkg::D_FKL+1:vio_pkg::D_FKL];
    assign fault_recorder_trigger = dest_q[vio_pkg::D_REC];

    // ========================================================
    // blocking matrix
    always_comb
    begin
        for (int s = 0; s < vio_pkg::NSTG; s++)
            next_block[s] = block_cfg[s][vio_pkg::F_EN]
                          & src[block_cfg[s][vio_pkg::F_IDX_MSB:0]]; // [RULE14]
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage_block          <= 4'h0;
            stage_blocked_status <= 4'h0;
        end
        else
        begin
            stage_block          <= next_block;
            stage_blocked_status <= next_block & stage_pickup; // [RULE15]
        end
    end

    // ========================================================
    // events and interrupt
    // a new change wins over a same-cycle clear
    assign next_st_vi = (st_vi & ~(wr_stvi ? hw_lo : 20'h00000))
                      | ((next_vi ^ stored_input_bits) & vi_ev_en); // [RULE17]
    assign next_st_vo = (st_vo & ~(wr_stvo ? hw_lo : 20'h00000))
                      | ((next_vo ^ stored_output_bits) & vo_ev_en); // [RULE17]

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_vi <= vio_pkg::R_BITS;
            st_vo <= vio_pkg::R_BITS;
            irq   <= 1'b0;
        end
        else
        begin
            st_vi <= next_st_vi;
            st_vo <= next_st_vo;
            irq   <= |((next_st_vi & ~mask_vi) | (next_st_vo & ~mask_vo));
        end
    end

    // ========================================================
    // checks
    wire [38:20] nl_v    = en_v[38:20] & ~lat_v[38:20];
    wire [38:20] hold_v  = lat_v[38:20] & dest_q & {19{~rel_now}};
    wire [38:20] ctl_hi  = ctl[38:20];
    wire         blk0_on = next_block[0];

    chk_vi_write_fast: assert property ( // [RULE2]
        @(posedge core_clk) disable iff (sys_rst)
        wr_vi |=> stored_input_bits == $past(hw_lo))
        else $error("virtual input write not applied next cycle");

    chk_vo_force_hold: assert property ( // [RULE4]
        @(posedge core_clk) disable iff (sys_rst)
        (force_on && !wr_vo) |=> $stable(stored_output_bits))
        else $error("forced virtual output changed without a write");

    chk_nonlatch_follow: assert property ( // [RULE10]
        @(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> ((dest_q ^ $past(ctl_hi)) & $past(nl_v)) == 19'h00000)
        else $error("non-latched destination not following control");

    chk_latch_hold: assert property ( // [RULE11]
        @(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> (dest_q & $past(hold_v)) == $past(hold_v))
        else $error("latched destination dropped without release");

    chk_release_clears: assert property ( // [RULE12]
        @(posedge core_clk) disable iff (sys_rst)
        rel_now |=> (dest_q & ~$past(ctl_hi)) == 19'h00000)
        else $error("release left a latched destination on");

    chk_block_route: assert property ( // [RULE14]
        @(posedge core_clk) disable iff (sys_rst)
        blk0_on |=> stage_block[0] ##1 (stage_block[0] == $past(blk0_on)))
        else $error("stage block not following its selected signal");

    chk_blocked_status: assert property ( // [RULE15]
        @(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> stage_blocked_status == (stage_block & $past(stage_pickup)))
        else $error("blocked status without block and pickup");

    chk_event_raise: assert property ( // [RULE17]
        @(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> ((stored_input_bits ^ $past(stored_input_bits))
                  & $past(vi_ev_en) & ~st_vi) == 20'h00000)
        else $error("enabled virtual input change left no event");

    chk_event_quiet: assert property ( // [RULE17]
        @(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> (st_vo & ~$past(st_vo) & ~$past(vo_ev_en)) == 20'h00000)
        else $error("event raised on a disabled virtual output");

    chk_read_wait: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ap && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");

endmodule
`default_nettype wire

// ==== vio_pkg.sv ====
// constants for the virtual input/output and signal matrix block
`default_nettype none
package vio_pkg;
    // ========================================================
    // sizes
    localparam int NVI   = 20;
    localparam int NVO   = 20;
    localparam int NDO   = 8;
    localparam int NLED  = 8;
    localparam int NSTG  = 4;
    localparam int NDI   = 8;
    localparam int NDEST = 39;
    // destination slots of the output matrix
    localparam int D_DO  = 20;
    localparam int D_LED = 28;
    localparam int D_FKL = 36;
    localparam int D_REC = 38;
    // ========================================================
    // register byte offsets
    localparam logic [7:0] A_VI    = 8'h00;
    localparam logic [7:0] A_VO    = 8'h04;
    localparam logic [7:0] A_CTRL  = 8'h08;
    localparam logic [7:0] A_FKEY  = 8'h0C;
    localparam logic [7:0] A_VIEV  = 8'h10;
    localparam logic [7:0] A_VOEV  = 8'h14;
    localparam logic [7:0] A_STVI  = 8'h18;
    localparam logic [7:0] A_STVO  = 8'h1C;
    localparam logic [7:0] A_MKVI  = 8'h20;
    localparam logic [7:0] A_MKVO  = 8'h24;
    localparam logic [7:0] A_BLOCK = 8'h28;
    localparam logic [7:0] A_BEND  = 8'h38;
    localparam logic [7:0] A_STAT  = 8'h38;
    localparam logic [7:0] A_ROUTE = 8'h40;
    localparam logic [7:0] A_REND  = 8'hDC;
    // ========================================================
    // field positions
    localparam int F_IDX_MSB = 5;
    localparam int F_EN      = 8;
    localparam int F_LAT     = 9;
    localparam int C_FORCE   = 0;
    localparam int C_REL     = 1;
    localparam int C_RDI_LSB = 8;
    localparam int C_RDI_MSB = 10;
    localparam int C_RDI_EN  = 11;
    localparam int K1_MSB    = 4;
    localparam int K1_EN     = 5;
    localparam int K2_LSB    = 8;
    localparam int K2_MSB    = 12;
    localparam int K2_EN     = 13;
    // ========================================================
    // reset values
    localparam logic [9:0]  R_ROUTE = 10'h000;
    localparam logic [8:0]  R_BLOCK = 9'h000;
    localparam logic [11:0] R_CTRL  = 12'h000;
    localparam logic [13:0] R_FKEY  = 14'h0000;
    localparam logic [19:0] R_BITS  = 20'h00000;
endpackage
`default_nettype wire

// ==== field_side_model.sv ====
// far-side model: protection stages and the remote release link
`timescale 1ns/100ps
`default_nettype none
module field_side_model
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] measure,
    input  wire logic       release_req,
    input  wire logic [3:0] stage_block,
    output logic      [3:0] stage_start,
    output logic      [3:0] stage_trip,
    output logic      [3:0] stage_pickup,
    output logic            remote_release
);
    // ========================================================
    // stages pick up on measure, start unless blocked, trip a cycle later
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage_pickup   <= 4'h0;
            stage_start    <= 4'h0;
            stage_trip     <= 4'h0;
            remote_release <= 1'b0;
        end
        else
        begin
            stage_pickup   <= measure;
            stage_start    <= measure & ~stage_block;
            stage_trip     <= stage_start & ~stage_block;
            remote_release <= release_req;
        end
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking testbench of the virtual input/output signal matrix
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ========================================================
    // signals
    logic        core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, irq;
    logic [7:0]  haddr, dig_in, digital_out, indicator;
    logic [1:0]  htrans, alarm, function_key_led;
    logic [31:0] hwdata, hrdata, rdv, v;
    logic        function_key_one, function_key_two, panel_release, remote_release;
    logic [3:0]  stage_start, stage_trip, stage_pickup, logic_out, measure;
    logic [3:0]  stage_block, stage_blocked_status;
    logic        mimic_we, mimic_value, fault_recorder_trigger, release_req;
    logic [4:0]  mimic_index;
    logic [19:0] stored_input_bits, stored_output_bits;
    logic [15:0] lf;
    int          n_mismatch, num_checks, cyc;
    wire  [38:0] dest_all;
    assign dest_all = {fault_recorder_trigger, function_key_led, indicator, digital_out,
                       stored_output_bits};
    // ========================================================
    // instances
    virtual_io_signal_matrix dut
    (
        .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready(hreadyout), .hwdata,
        .hreadyout, .hresp, .hrdata, .dig_in, .function_key_one, .function_key_two,
        .panel_release, .remote_release, .stage_start, .stage_trip, .stage_pickup, .logic_out,
        .alarm, .mimic_we, .mimic_index, .mimic_value, .stored_input_bits, .stored_output_bits,
        .digital_out, .indicator, .function_key_led, .fault_recorder_trigger, .stage_block,
        .stage_blocked_status, .irq
    );
    field_side_model far_side
    (
        .core_clk, .sys_rst, .measure, .release_req, .stage_block, .stage_start, .stage_trip,
        .stage_pickup, .remote_release
    );
    // ========================================================
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] route_word(input int src, input logic lat);
        return 32'h100 | (32'(src) & 32'h3F) | (32'(lat) << 9);
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wait_ready();
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
            @(posedge core_clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdv, exp);
        chk(hresp, 1'b0);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ========================================================
    // clock and timeout
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    // ========================================================
    // main sequence
    initial
    begin
        sys_rst = 1'b1; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
        hwdata = 32'h0; dig_in = 8'h00; function_key_one = 1'b0; function_key_two = 1'b0;
        panel_release = 1'b0; logic_out = 4'h0; alarm = 2'h0; mimic_we = 1'b0;
        mimic_index = 5'h00; mimic_value = 1'b0; measure = 4'h0; release_req = 1'b0;
        n_mismatch = 0; num_checks = 0; cyc = 0; lf = 16'h0053;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rdc(vio_pkg::A_VI, 32'h0);
        rdc(vio_pkg::A_STAT, 32'h0);
        rdc(8'hE0, 32'h0);
        wr(vio_pkg::A_ROUTE + 8'(4 * 20), route_word(56, 1'b0));
        wr(vio_pkg::A_ROUTE + 8'(4 * 21), route_word(60, 1'b0));
        // random virtual input values, then all ones into reserved bits
        for (int i = 0; i < 5; i++)
        begin
            lf = lfsr_next(lf);
            v = (i == 4) ? 32'hFFFFFFFF : (32'(lf) << 4) ^ 32'(lf);
            logic_out <= lf[3:0];
            alarm <= lf[5:4];
            wr(vio_pkg::A_VI, v);
            tick(1);
            chk(stored_input_bits, v[19:0]);
            chk(digital_out[1:0], {lf[4], lf[0]});
            rdc(vio_pkg::A_VI, v & 32'hFFFFF);
        end
        logic_out <= 4'h0;
        alarm <= 2'h0;
        // outputs writable only while forced, with events
        wr(vio_pkg::A_VOEV, 32'h1);
        wr(vio_pkg::A_VO, 32'h12345);
        rdc(vio_pkg::A_VO, 32'h0);
        wr(vio_pkg::A_CTRL, 32'h1);
        wr(vio_pkg::A_VO, 32'hABCDF);
        tick(1);
        chk(stored_output_bits, 20'hABCDF);
        rdc(vio_pkg::A_STVO, 32'h1);
        wr(vio_pkg::A_CTRL, 32'h0);
        wr(vio_pkg::A_VOEV, 32'h0);
        wr(vio_pkg::A_STVO, 32'hFFFFF);
        wr(vio_pkg::A_VI, 32'h0);
        // every destination follows a routed virtual input
        for (int d = 0; d < vio_pkg::NDEST; d++)
        begin
            wr(vio_pkg::A_ROUTE + 8'(4 * d), route_word(d % 20, 1'b0));
            wr(vio_pkg::A_VI, 32'h1 << (d % 20));
            tick(3);
            chk(dest_all, 39'h1 << d);
            wr(vio_pkg::A_VI, 32'h0);
            tick(3);
            chk(dest_all, 39'h0);
            wr(vio_pkg::A_ROUTE + 8'(4 * d), 32'h0);
        end
        // latched destinations and every release source
        wr(vio_pkg::A_ROUTE + 8'(4 * 28), route_word(1, 1'b1));
        wr(vio_pkg::A_ROUTE + 8'(4 * 20), route_word(1, 1'b1));
        wr(vio_pkg::A_ROUTE + 8'(4 * 21), 32'hFFFFFDC1);
        rdc(vio_pkg::A_ROUTE + 8'(4 * 21), 32'h101);
        wr(vio_pkg::A_CTRL, 32'hB00);
        for (int k = 0; k < 4; k++)
        begin
            wr(vio_pkg::A_VI, 32'h2);
            tick(3);
            wr(vio_pkg::A_VI, 32'h0);
            tick(3);
            chk({indicator[0], digital_out[1:0]}, 3'b101);
            if (k == 0)
                wr(vio_pkg::A_CTRL, 32'hB02);
            release_req <= (k == 1);
            panel_release <= (k == 2);
            dig_in <= (k == 3) ? 8'h08 : 8'h00;
            tick(4);
            release_req <= 1'b0;
            panel_release <= 1'b0;
            dig_in <= 8'h00;
            tick(4);
            chk({indicator[0], digital_out[1:0]}, 3'b000);
        end
        // blocking by a digital input and by another stage's trip
        wr(vio_pkg::A_BLOCK, 32'h128);
        wr(vio_pkg::A_BLOCK + 8'h04, 32'h136);
        dig_in <= 8'h01;
        measure <= 4'h7;
        tick(8);
        chk(stage_block, 4'h3);
        chk(stage_blocked_status, 4'h3);
        measure <= 4'h0;
        tick(6);
        chk({stage_block, stage_blocked_status}, 8'h10);
        dig_in <= 8'h00;
        tick(5);
        chk(stage_block, 4'h0);
        // events, mask and write-one-to-clear
        wr(vio_pkg::A_VIEV, 32'h1);
        wr(vio_pkg::A_VI, 32'h3);
        tick(2);
        chk(irq, 1'b1);
        rdc(vio_pkg::A_STVI, 32'h1);
        wr(vio_pkg::A_MKVI, 32'h1);
        tick(2);
        chk(irq, 1'b0);
        wr(vio_pkg::A_STVI, 32'h1);
        wr(vio_pkg::A_MKVI, 32'h0);
        wr(vio_pkg::A_VI, 32'h3);
        tick(2);
        rdc(vio_pkg::A_STVI, 32'h0);
        chk(irq, 1'b0);
        // mimic and function keys
        wr(vio_pkg::A_VIEV, 32'h0);
        wr(vio_pkg::A_VI, 32'h0);
        mimic_we <= 1'b1;
        mimic_index <= 5'd7;
        mimic_value <= 1'b1;
        tick(1);
        mimic_index <= 5'd25;
        tick(1);
        mimic_we <= 1'b0;
        tick(2);
        chk(stored_input_bits, 20'h00080);
        wr(vio_pkg::A_FKEY, 32'h2A29);
        function_key_one <= 1'b1;
        tick(5);
        function_key_one <= 1'b0;
        function_key_two <= 1'b1;
        tick(5);
        function_key_two <= 1'b0;
        tick(2);
        chk(stored_input_bits, 20'h00680);
        test_done();
    end
endmodule
`default_nettype wire
